// file: overlay_map_pkg.sv
// constants, types and field layout shared by the memory-overlay decoder
// How it works
// (RL1) cycle starts only on a strobe's falling edge
// (RL2) cycle ends on rising edge of starting strobe
// (RL3) target must not trust memory-cycle line alone
// (RL4) mapped accesses ignore target ready
// (RL5) always drive target; discard target data when mapped
// (RL6) two 64K expansion pages, 1K blocks, protectable
// (RL7) static overlay RAM replaces lowest 1K block
// (RL8) reset leaves nothing mapped, all to target
// (RL9) on-chip RAM F000-F0FA and FFFA-FFFF served internally
// (RL10) overlay at 0000-03FF beats expansion and target
// (RL11) read-only blocks take writes only in control mode
// (RL12) base rounds down to 1K; no wrap past top
// (RL13) 64-entry table by address bits 15..10
// (RL14) priority on-chip, overlay, expansion, then target
package overlay_map_pkg;

  // ---------------------------------------------------------------
  // bus widths and clock
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          CLK_PERIOD_NS = 25;

  // ---------------------------------------------------------------
  // block table layout
  // ---------------------------------------------------------------
  localparam int          BLK_MSB       = 15;
  localparam int          BLK_LSB       = 10;
  localparam int          BLK_W         = BLK_MSB - BLK_LSB + 1;
  localparam int          NUM_BLOCKS    = 64;
  localparam int          COUNT_W       = 7;
  localparam logic [7:0]  BLK_LIMIT     = 8'h40;

  // ---------------------------------------------------------------
  // fixed address windows
  // ---------------------------------------------------------------
  localparam logic [15:0] ONCHIP_LO_START = 16'hF000;
  localparam logic [15:0] ONCHIP_LO_END   = 16'hF0FA;
  localparam logic [15:0] ONCHIP_HI_START = 16'hFFFA;
  localparam logic [15:0] OVERLAY_START   = 16'h0000;
  localparam logic [15:0] OVERLAY_END     = 16'h03FF;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        OVERLAY_EN_RESET = 1'b0;
  localparam logic [15:0] DATA_RESET       = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BLK_UNMAPPED  = 2'h0,
    BLK_READ_ONLY = 2'h1,
    BLK_READ_WRITE = 2'h2
  } blk_state_t;

  typedef enum logic [1:0] {
    REGION_TARGET    = 2'h0,
    REGION_ONCHIP    = 2'h1,
    REGION_OVERLAY   = 2'h2,
    REGION_EXPANSION = 2'h3
  } region_t;

  typedef enum logic [1:0] {
    CYC_IDLE   = 2'b00,
    CYC_ACTIVE = 2'b01,
    CYC_CLOSE  = 2'b11
  } cyc_state_t;

endpackage

// file: block_table.sv
// 64-entry expansion block table with range load and lookup
`timescale 1ns/100ps
`default_nettype none
module block_table
  import overlay_map_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // range load from the control side
  input  wire logic               load,
  input  wire logic [ADDR_W-1:0]  base_addr,
  input  wire logic [COUNT_W-1:0] block_count,
  input  wire blk_state_t         new_state,
  input  wire logic               new_page,
  // lookup
  input  wire logic [BLK_W-1:0]   lookup_index,
  output blk_state_t              entry_state,
  output logic                    entry_page
);

  blk_state_t state_reg [NUM_BLOCKS];
  blk_state_t state_next [NUM_BLOCKS];
  logic       page_reg  [NUM_BLOCKS];
  logic       page_next [NUM_BLOCKS];
  logic [7:0] first_blk;
  logic [7:0] last_blk;

  // ---------------------------------------------------------------
  // range decode: the low ten address bits are simply dropped
  // ---------------------------------------------------------------
  assign first_blk = {2'b00, base_addr[BLK_MSB:BLK_LSB]}; // RL12
  assign last_blk  = first_blk + {1'b0, block_count};     // RL12

  // every entry inside [first, last) and below the top takes the load
  always_comb begin
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      state_next[i] = state_reg[i];
      page_next[i]  = page_reg[i];
      if (load && (8'(i) >= first_blk) && (8'(i) < last_blk) && (8'(i) < BLK_LIMIT)) begin // RL12
        state_next[i] = new_state; // RL6
        page_next[i]  = new_page;  // RL6
      end
    end
  end

  // reset unmaps every block
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (!resetn) begin
        state_reg[i] <= BLK_UNMAPPED; // RL8
        page_reg[i]  <= 1'b0;
      end else begin
        state_reg[i] <= state_next[i];
        page_reg[i]  <= page_next[i];
      end
    end
  end

  // lookup by address bits 15..10
  assign entry_state = state_reg[lookup_index]; // RL13
  assign entry_page  = page_reg[lookup_index];  // RL13

endmodule
`default_nettype wire

// file: overlay_map.sv
// memory-overlay decoder: cycle framing, region select and ready/data steering
`timescale 1ns/100ps
`default_nettype none
module overlay_map
  import overlay_map_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // processor bus pins
  input  wire logic               read_strobe_n,
  input  wire logic               write_strobe_n,
  input  wire logic [ADDR_W-1:0]  cpu_addr,
  output logic                    cpu_ready,
  output logic [DATA_W-1:0]       cpu_rdata,
  // target bus pins
  output logic                    target_read_n,
  output logic                    target_write_n,
  output logic [ADDR_W-1:0]       target_addr,
  input  wire logic               target_ready,
  input  wire logic [DATA_W-1:0]  target_rdata,
  // emulator memories
  output logic                    overlay_sel,
  output logic                    overlay_we,
  input  wire logic [DATA_W-1:0]  overlay_rdata,
  output logic                    exp_sel,
  output logic                    exp_we,
  output logic                    exp_page,
  input  wire logic [DATA_W-1:0]  exp_rdata,
  output logic                    onchip_sel,
  input  wire logic [DATA_W-1:0]  onchip_rdata,
  // monitor control
  input  wire logic               run_mode,
  input  wire logic               overlay_cfg_load,
  input  wire logic               overlay_cfg_on,
  input  wire logic               map_load,
  input  wire logic [ADDR_W-1:0]  map_base,
  input  wire logic [COUNT_W-1:0] map_count,
  input  wire blk_state_t         map_state,
  input  wire logic               map_page,
  // status
  output logic                    cycle_active
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic              rd_meta_reg, rd_sync_reg, rd_prev_reg;
  logic              wr_meta_reg, wr_sync_reg, wr_prev_reg;
  logic              rdy_meta_reg, rdy_sync_reg;
  logic [ADDR_W-1:0] addr_meta_reg, addr_sync_reg;
  logic [DATA_W-1:0] tdat_meta_reg, tdat_sync_reg;

  // strobes idle high so reset preloads ones and no false edge appears
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_meta_reg   <= 1'b1;
      rd_sync_reg   <= 1'b1;
      rd_prev_reg   <= 1'b1;
      wr_meta_reg   <= 1'b1;
      wr_sync_reg   <= 1'b1;
      wr_prev_reg   <= 1'b1;
      rdy_meta_reg  <= 1'b0;
      rdy_sync_reg  <= 1'b0;
      addr_meta_reg <= 16'h0000;
      addr_sync_reg <= 16'h0000;
      tdat_meta_reg <= DATA_RESET;
      tdat_sync_reg <= DATA_RESET;
    end else begin
      rd_meta_reg   <= read_strobe_n;
      rd_sync_reg   <= rd_meta_reg;
      rd_prev_reg   <= rd_sync_reg;
      wr_meta_reg   <= write_strobe_n;
      wr_sync_reg   <= wr_meta_reg;
      wr_prev_reg   <= wr_sync_reg;
      rdy_meta_reg  <= target_ready;
      rdy_sync_reg  <= rdy_meta_reg;
      addr_meta_reg <= cpu_addr;
      addr_sync_reg <= addr_meta_reg;
      tdat_meta_reg <= target_rdata;
      tdat_sync_reg <= tdat_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // strobe edges; nothing else opens a cycle, so a halted processor
  // holding its memory line low never looks like an access
  // ---------------------------------------------------------------
  logic rd_fall, wr_fall, rd_rise, wr_rise;
  assign rd_fall = rd_prev_reg & ~rd_sync_reg; // RL1
  assign wr_fall = wr_prev_reg & ~wr_sync_reg; // RL1
  assign rd_rise = ~rd_prev_reg & rd_sync_reg; // RL2
  assign wr_rise = ~wr_prev_reg & wr_sync_reg; // RL2

  // ---------------------------------------------------------------
  // overlay enable and block table
  // ---------------------------------------------------------------
  logic       ovl_en_reg, ovl_en_next;
  blk_state_t entry_state;
  logic       entry_page;

  always_comb begin
    ovl_en_next = overlay_cfg_load ? overlay_cfg_on : ovl_en_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ovl_en_reg <= OVERLAY_EN_RESET; // RL8
    end else begin
      ovl_en_reg <= ovl_en_next;
    end
  end

  block_table u_block_table (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .load         (map_load),
    .base_addr    (map_base),
    .block_count  (map_count),
    .new_state    (map_state),
    .new_page     (map_page),
    .lookup_index (addr_sync_reg[BLK_MSB:BLK_LSB]),
    .entry_state  (entry_state),
    .entry_page   (entry_page)
  );

  // ---------------------------------------------------------------
  // region priority for the address now on the bus
  // ---------------------------------------------------------------
  region_t region_now;

  always_comb begin
    if ((addr_sync_reg >= ONCHIP_LO_START && addr_sync_reg <= ONCHIP_LO_END) ||
        (addr_sync_reg >= ONCHIP_HI_START)) begin
      region_now = REGION_ONCHIP;                                   // RL9 RL14
    end else if (ovl_en_reg && addr_sync_reg >= OVERLAY_START && addr_sync_reg <= OVERLAY_END) begin
      region_now = REGION_OVERLAY;                                  // RL7 RL10 RL14
    end else if (entry_state != BLK_UNMAPPED) begin
      region_now = REGION_EXPANSION;                                // RL6 RL14
    end else begin
      region_now = REGION_TARGET;                                   // RL14
    end
  end

  // ---------------------------------------------------------------
  // cycle state machine and registered outputs
  // ---------------------------------------------------------------
  cyc_state_t        cyc_reg, cyc_next;
  region_t           region_reg, region_next;
  logic              is_wr_reg, is_wr_next;
  logic              rom_reg, rom_next;
  logic              page_reg, page_next;
  logic [ADDR_W-1:0] taddr_reg, taddr_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              trd_reg, trd_next;
  logic              twr_reg, twr_next;

  always_comb begin
    cyc_next    = cyc_reg;
    region_next = region_reg;
    is_wr_next  = is_wr_reg;
    rom_next    = rom_reg;
    page_next   = page_reg;
    taddr_next  = taddr_reg;
    rdata_next  = rdata_reg;
    trd_next    = 1'b1;
    twr_next    = 1'b1;
    case (cyc_reg)
      CYC_IDLE: begin
        // a write edge wins if both strobes fall together
        if (wr_fall || rd_fall) begin                               // RL1
          cyc_next    = CYC_ACTIVE;
          is_wr_next  = wr_fall;
          region_next = region_now;
          rom_next    = (entry_state == BLK_READ_ONLY);
          page_next   = entry_page;
          taddr_next  = addr_sync_reg;
        end
      end
      CYC_ACTIVE: begin
        // the target sees every access whatever the mapping
        trd_next = is_wr_reg;                                       // RL5
        twr_next = ~is_wr_reg;                                      // RL5
        if (!is_wr_reg) begin
          case (region_reg)
            REGION_ONCHIP:    rdata_next = onchip_rdata;
            REGION_OVERLAY:   rdata_next = overlay_rdata;           // RL5
            REGION_EXPANSION: rdata_next = exp_rdata;               // RL5
            default:          rdata_next = rdy_sync_reg ? tdat_sync_reg : rdata_reg;
          endcase
        end
        if ((is_wr_reg && wr_rise) || (!is_wr_reg && rd_rise)) begin // RL2
          cyc_next = CYC_CLOSE;
          trd_next = 1'b1;
          twr_next = 1'b1;
        end
      end
      CYC_CLOSE: begin
        cyc_next = CYC_IDLE;
      end
      default: begin
        cyc_next = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cyc_reg    <= CYC_IDLE;
      region_reg <= REGION_TARGET; // RL8
      is_wr_reg  <= 1'b0;
      rom_reg    <= 1'b0;
      page_reg   <= 1'b0;
      taddr_reg  <= 16'h0000;
      rdata_reg  <= DATA_RESET;
      trd_reg    <= 1'b1;
      twr_reg    <= 1'b1;
    end else begin
      cyc_reg    <= cyc_next;
      region_reg <= region_next;
      is_wr_reg  <= is_wr_next;
      rom_reg    <= rom_next;
      page_reg   <= page_next;
      taddr_reg  <= taddr_next;
      rdata_reg  <= rdata_next;
      trd_reg    <= trd_next;
      twr_reg    <= twr_next;
    end
  end

  // ---------------------------------------------------------------
  // output steering
  // ---------------------------------------------------------------
  logic active, mapped;
  assign active = (cyc_reg == CYC_ACTIVE);
  assign mapped = (region_reg != REGION_TARGET);

  // mapped regions answer at once; the target's ready counts only when unmapped
  assign cpu_ready      = active & (mapped | rdy_sync_reg);                // RL4
  assign cpu_rdata      = rdata_reg;
  assign target_read_n  = trd_reg;
  assign target_write_n = twr_reg;
  assign target_addr    = taddr_reg;
  assign onchip_sel     = active & (region_reg == REGION_ONCHIP);          // RL9
  assign overlay_sel    = active & (region_reg == REGION_OVERLAY);         // RL7
  assign overlay_we     = overlay_sel & is_wr_reg;
  assign exp_sel        = active & (region_reg == REGION_EXPANSION);       // RL6
  // read-only blocks stay writable from the monitor, never while running
  assign exp_we         = exp_sel & is_wr_reg & ~(rom_reg & run_mode);     // RL11
  assign exp_page       = page_reg;
  assign cycle_active   = active;

endmodule
`default_nettype wire

// file: overlay_map_properties.sv
// checker holding the concurrent properties of the overlay decoder
`timescale 1ns/100ps
`default_nettype none
module overlay_map_chk
  import overlay_map_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // watched pins
  input wire logic              read_strobe_n,
  input wire logic              write_strobe_n,
  input wire logic              cpu_ready,
  input wire logic              target_read_n,
  input wire logic              target_write_n,
  input wire logic [ADDR_W-1:0] target_addr,
  input wire logic              target_ready,
  input wire logic              overlay_sel,
  input wire logic              overlay_we,
  input wire logic              exp_sel,
  input wire logic              exp_we,
  input wire logic              onchip_sel,
  input wire logic              cycle_active
);
  // ----
  // single domain, reset masks all
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // a strobe rises while the other stays high
  sequence rd_done;
    $rose(read_strobe_n) && write_strobe_n;
  endsequence
  sequence wr_done;
    $rose(write_strobe_n) && read_strobe_n;
  endsequence
  // ----
  // properties
  // ----
  cyc_start_a : assert property (
    $rose(cycle_active) |-> !$past(read_strobe_n, 2) || !$past(write_strobe_n, 2))
    else $error("cycle began without a strobe fall");
  cyc_close_a : assert property (
    cycle_active ##0 (rd_done or wr_done) |-> ##[1:5] !cycle_active)
    else $error("cycle did not end after strobe rise");
  idle_quiet_a : assert property (
    !cycle_active |-> !(overlay_sel || exp_sel || onchip_sel || cpu_ready))
    else $error("select or ready outside a cycle");
  mapped_ready_a : assert property (
    overlay_sel || exp_sel |-> cpu_ready)
    else $error("mapped access waited for target ready");
  target_ready_a : assert property (
    cpu_ready && !overlay_sel && !exp_sel && !onchip_sel |-> $past(target_ready, 2) || $past(target_ready, 3))
    else $error("unmapped ready without target ready");
  target_drive_a : assert property (
    cycle_active [*3] |-> !target_read_n || !target_write_n)
    else $error("access not driven to target");
  overlay_addr_a : assert property (
    overlay_sel && $past(overlay_sel) |-> target_addr <= OVERLAY_END)
    else $error("overlay selected outside its block");
  onchip_addr_a : assert property (
    onchip_sel && $past(onchip_sel) |-> target_addr >= ONCHIP_HI_START
      || (target_addr >= ONCHIP_LO_START && target_addr <= ONCHIP_LO_END))
    else $error("on-chip selected outside its ranges");
  sel_onehot_a : assert property (
    $onehot0({overlay_sel, exp_sel, onchip_sel}) && (!exp_we || exp_sel) && (!overlay_we || overlay_sel))
    else $error("more than one region selected");
endmodule
`default_nettype wire

// file: target_mem_model.sv
// behavioural target memory on the emulated processor bus
`timescale 1ns/100ps
`default_nettype none
module target_mem_model
  import overlay_map_pkg::*;
#(
  parameter int          DLY     = 2,
  parameter logic [15:0] RD_WORD = 16'hA5A5
)(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // target bus
  input  wire logic              target_read_n,
  input  wire logic              target_write_n,
  output logic                   target_ready,
  output logic [DATA_W-1:0]      target_rdata,
  // test control and status
  input  wire logic              stall,
  output logic [7:0]             wr_cnt
);
  logic [3:0] wait_cnt;
  logic       wr_seen;
  // access judged from the strobes alone, never from a cycle flag
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      target_ready <= 1'b0;
      target_rdata <= 16'h0000;
      wr_cnt <= 8'h00;
      wr_seen <= 1'b0;
    end else if (target_read_n && target_write_n) begin
      wait_cnt <= 4'h0;
      target_ready <= 1'b0;
      target_rdata <= ~target_rdata; // released bus never repeats a word
      wr_seen <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + ((wait_cnt < 4'hF) ? 4'h1 : 4'h0);
      target_ready <= (wait_cnt >= DLY) && !stall; // slow or stalled
      if (!target_read_n) target_rdata <= RD_WORD;
      if (!target_write_n && !wr_seen) wr_cnt <= wr_cnt + 8'h01;
      wr_seen <= !target_write_n;
    end
  end
endmodule
`default_nettype wire

// file: overlay_map_tb.sv
// self-checking bench for the memory-overlay decoder
`timescale 1ns/100ps
`default_nettype none
module overlay_map_tb;
  import overlay_map_pkg::*;
  // ----
  // signals
  // ----
  logic        core_clk = 1'b0, resetn = 1'b0, stall = 1'b0, run_mode = 1'b1;
  logic        read_strobe_n = 1'b1, write_strobe_n = 1'b1;
  logic        overlay_cfg_load = 1'b0, overlay_cfg_on = 1'b0;
  logic        map_load = 1'b0, map_page = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, map_base = 16'h0000;
  logic [6:0]  map_count = 7'h00;
  blk_state_t  map_state = BLK_UNMAPPED;
  logic        cpu_ready, target_read_n, target_write_n, target_ready, cycle_active;
  logic        overlay_sel, overlay_we, exp_sel, exp_we, exp_page, onchip_sel;
  logic [15:0] cpu_rdata, target_addr, target_rdata;
  logic [7:0]  wr_cnt, msk = 8'hFF;
  int          error_cnt = 0, total_checks = 0, cyc_cnt = 0;
  // ----
  // clock, design and target memory
  // ----
  always #12.5 core_clk = ~core_clk;
  overlay_map overlay_map_inst (.core_clk, .resetn, .read_strobe_n, .write_strobe_n, .cpu_addr,
    .cpu_ready, .cpu_rdata, .target_read_n, .target_write_n, .target_addr, .target_ready,
    .target_rdata, .overlay_sel, .overlay_we, .overlay_rdata(16'h1111), .exp_sel, .exp_we,
    .exp_page, .exp_rdata(16'h2222), .onchip_sel, .onchip_rdata(16'h3333), .run_mode,
    .overlay_cfg_load, .overlay_cfg_on, .map_load, .map_base, .map_count, .map_state,
    .map_page, .cycle_active);
  target_mem_model target_mem_model_inst (.core_clk, .resetn, .target_read_n, .target_write_n,
    .target_ready, .target_rdata, .stall, .wr_cnt);
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // flags: overlay, exp, onchip, ready, trd_n, twr_n, exp_we, page
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] es, input logic [15:0] ed);
    int n;
    logic [7:0] s;
    @(negedge core_clk) cpu_addr = a;
    @(negedge core_clk);
    if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    n = 0;
    while (cycle_active !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    repeat (12) @(negedge core_clk);
    s = {overlay_sel, exp_sel, onchip_sel, cpu_ready, target_read_n, target_write_n, exp_we, exp_page & exp_sel};
    chk("flags", {8'h00, es & msk}, {8'h00, s & msk});
    if (!wr) chk("rdata", ed, cpu_rdata);
    chk("ovl_we", {15'h0, wr & es[7]}, {15'h0, overlay_we});
    if (msk[3]) chk("taddr", a, target_addr);
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    n = 0;
    while (cycle_active !== 1'b0 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    repeat (3) @(negedge core_clk);
  endtask
  // one-cycle load pulses: each taken on a single edge
  task automatic cfg(input logic on);
    @(negedge core_clk) overlay_cfg_on = on;
    overlay_cfg_load = 1'b1;
    @(negedge core_clk) overlay_cfg_load = 1'b0;
  endtask
  task automatic mapl(input logic [15:0] b, input logic [6:0] c, input blk_state_t st, input logic pg);
    @(negedge core_clk) map_base = b;
    map_count = c;
    map_state = st;
    map_page = pg;
    map_load = 1'b1;
    @(negedge core_clk) map_load = 1'b0;
    @(negedge core_clk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk("ready_idle", 16'h0000, {15'h0, cpu_ready});
    chk("trd_idle", 16'h0001, {15'h0, target_read_n});
    chk("rdata_rst", DATA_RESET, cpu_rdata);
    acc(1'b0, 16'h0000, 8'h14, 16'hA5A5);
    acc(1'b0, 16'hFC00, 8'h14, 16'hA5A5);
  endtask
  task automatic t_onchip;
    logic [15:0] oa [4] = '{16'hF000, 16'hF0FA, 16'hFFFA, 16'hFFFF};
    msk = 8'hF0; // target side of on-chip cycles is left open
    for (int i = 0; i < 4; i++) acc(1'b0, oa[i], 8'h30, 16'h3333);
    msk = 8'hFF;
    acc(1'b0, 16'hF0FB, 8'h14, 16'hA5A5);
    acc(1'b0, 16'hFFF9, 8'h14, 16'hA5A5);
  endtask
  task automatic t_overlay;
    logic [7:0] w0;
    cfg(1'b1);
    stall = 1'b1; // target never answers: mapped cycles must not care
    acc(1'b0, 16'h0000, 8'h94, 16'h1111);
    acc(1'b0, 16'h03FF, 8'h94, 16'h1111);
    w0 = wr_cnt;
    acc(1'b1, 16'h0002, 8'h98, 16'h0000);
    chk("target_wr", {8'h00, w0 + 8'h01}, {8'h00, wr_cnt});
    acc(1'b1, 16'h0400, 8'h08, 16'h0000);
    stall = 1'b0;
    acc(1'b0, 16'h0400, 8'h14, 16'hA5A5);
  endtask
  task automatic t_expand;
    mapl(16'h81C4, 7'h02, BLK_READ_WRITE, 1'b1);
    acc(1'b0, 16'h8000, 8'h55, 16'h2222);
    acc(1'b1, 16'h87FF, 8'h5B, 16'h0000);
    acc(1'b0, 16'h8800, 8'h14, 16'hA5A5);
    acc(1'b0, 16'h7FFF, 8'h14, 16'hA5A5);
    mapl(16'hFC00, 7'h7F, BLK_READ_ONLY, 1'b0);
    acc(1'b0, 16'hFC00, 8'h54, 16'h2222);
    acc(1'b0, 16'h0400, 8'h14, 16'hA5A5);
    mapl(16'h0000, 7'h01, BLK_READ_WRITE, 1'b0);
    acc(1'b0, 16'h0000, 8'h94, 16'h1111);
    msk = 8'hF0;
    acc(1'b0, 16'hFFFA, 8'h30, 16'h3333);
    msk = 8'hFF;
  endtask
  task automatic t_protect;
    acc(1'b1, 16'hFC00, 8'h58, 16'h0000);
    run_mode = 1'b0;
    acc(1'b1, 16'hFC00, 8'h5A, 16'h0000);
    mapl(16'h8000, 7'h02, BLK_UNMAPPED, 1'b0);
    acc(1'b0, 16'h8000, 8'h14, 16'hA5A5);
    cfg(1'b0);
    acc(1'b0, 16'h0000, 8'h54, 16'h2222);
  endtask
  task automatic t_frame;
    @(negedge core_clk) cpu_addr = 16'h0400;
    repeat (8) @(negedge core_clk);
    chk("no_strobe", 16'h0000, {15'h0, cycle_active});
    read_strobe_n = 1'b0;
    repeat (6) @(negedge core_clk);
    write_strobe_n = 1'b0;
    repeat (2) @(negedge core_clk);
    write_strobe_n = 1'b1;
    repeat (20) @(negedge core_clk);
    chk("held", 16'h0001, {15'h0, cycle_active});
    chk("other_strobe", 16'h0001, {15'h0, target_write_n});
    read_strobe_n = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("closed", 16'h0000, {15'h0, cycle_active});
    // both strobes falling together must open a write cycle
    write_strobe_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (10) @(negedge core_clk);
    chk("both_fall", 16'h0000, {15'h0, target_write_n});
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("both_closed", 16'h0000, {15'h0, cycle_active});
  endtask
  // ----
  // sequence, hang guard and verdict
  // ----
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    t_reset;
    t_onchip;
    t_overlay;
    t_expand;
    t_protect;
    t_frame;
    print_verdict;
  end
endmodule
bind overlay_map overlay_map_chk overlay_map_chk_inst (.core_clk, .resetn, .read_strobe_n,
  .write_strobe_n, .cpu_ready, .target_read_n, .target_write_n, .target_addr, .target_ready,
  .overlay_sel, .overlay_we, .exp_sel, .exp_we, .onchip_sel, .cycle_active);
`default_nettype wire
